// ===== shared/tdc_pkg.sv
// What this block does
// - With the long-shift enable bit set, interruptions over 30 ms up to a 32-35 ms selected maximum also count as phase shifts; when clear they do not.
// - Disable-tone evaluation ends when no phase shift is seen within 749, 833, 916 or 999 ms, chosen by a 2-bit code.
// - A continuity-check configuration byte of zero switches 2010 Hz tone detection off entirely.
// - The coefficient store is reset once the 2010 Hz tone has lasted code times 8 ms; code zero never resets.
// - The canceller is bypassed once the 2010 Hz tone has lasted code times 8 ms; code zero never bypasses.
// - The phase-shift configuration register sits at 1CH, is write protected and resets to 43H.
package tdc_pkg;
   // ==========================================
   // clock and decision tick
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 125000;
   localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_US       = TICK_NS / 1000;
   localparam int US_PER_MS     = 1000;

   // ==========================================
   // register map
   localparam logic [7:0] ADDR_PSD  = 8'h1C;
   localparam logic [7:0] ADDR_CC   = 8'h1D;
   localparam logic [7:0] ADDR_STAT = 8'h1E;
   localparam logic [7:0] RST_PSD   = 8'h43;
   localparam logic [7:0] RST_CC    = 8'h00;

   // ==========================================
   // times as printed
   localparam int EVAL_MS_0     = 749;
   localparam int EVAL_MS_1     = 833;
   localparam int EVAL_MS_2     = 916;
   localparam int EVAL_MS_3     = 999;
   localparam int MIN_STEP_US   = 1125;
   localparam int MAX_MS_0      = 27;
   localparam int MAX_MS_1      = 28;
   localparam int MAX_MS_2      = 29;
   localparam int MAX_MS_3      = 30;
   localparam int MAX_MS_4      = 32;
   localparam int MAX_MS_5      = 33;
   localparam int MAX_MS_6      = 34;
   localparam int MAX_MS_7      = 35;
   localparam int LONG_SHIFT_MS = 30;
   localparam int PROT_STEP_MS  = 8;
   localparam int PROT_MAX_MS   = 120;

   // ==========================================
   // carriers
   typedef struct packed {
      logic       longShiftEvalEnable;
      logic [1:0] evaluationTimeSelect;
      logic [1:0] minInterruptionSelect;
      logic [2:0] maxInterruptionSelect;
   } tdc_psd_cfg_t;

   typedef struct packed {
      logic [3:0] coeffResetProtectTime;
      logic [3:0] bypassProtectTime;
   } tdc_cc_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic       wrStb;
      logic       rdStb;
   } tdc_bus_req_t;
endpackage

// ===== src/tdc_tone_detector_control.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module tdc_tone_detector_control #(
   parameter int TICK_CYCLES = tdc_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 srst,
   // register port
   input  wire tdc_pkg::tdc_bus_req_t regReq,
   input  wire logic                 cfgUnlock,
   output logic [7:0]                regRdData,
   // tone presence from the filters
   input  wire logic                 disTonePresent,
   input  wire logic                 ccTonePresent,
   // decisions
   output logic                      phaseShiftDetected,
   output logic                      evalExpired,
   output logic                      coeffStoreReset,
   output logic                      cancellerBypass
);
   import tdc_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int TPMS = US_PER_MS / TICK_US;
   localparam logic [12:0] LONG_TICKS = 13'(LONG_SHIFT_MS * TPMS);
   localparam logic [9:0]  CC_SAT     = 10'(PROT_MAX_MS * TPMS);

   typedef enum logic [1:0] {PS_IDLE, PS_EVAL, PS_GAP, PS_HOLD} tdc_ps_state_t;

   function automatic logic [12:0] evalTicks(input logic [1:0] sel);
      case (sel)
         2'h0:    evalTicks = 13'(EVAL_MS_0 * TPMS);
         2'h1:    evalTicks = 13'(EVAL_MS_1 * TPMS);
         2'h2:    evalTicks = 13'(EVAL_MS_2 * TPMS);
         default: evalTicks = 13'(EVAL_MS_3 * TPMS);
      endcase
   endfunction

   function automatic logic [12:0] maxTicks(input logic [2:0] sel);
      case (sel)
         3'h0:    maxTicks = 13'(MAX_MS_0 * TPMS);
         3'h1:    maxTicks = 13'(MAX_MS_1 * TPMS);
         3'h2:    maxTicks = 13'(MAX_MS_2 * TPMS);
         3'h3:    maxTicks = 13'(MAX_MS_3 * TPMS);
         3'h4:    maxTicks = 13'(MAX_MS_4 * TPMS);
         3'h5:    maxTicks = 13'(MAX_MS_5 * TPMS);
         3'h6:    maxTicks = 13'(MAX_MS_6 * TPMS);
         default: maxTicks = 13'(MAX_MS_7 * TPMS);
      endcase
   endfunction

   // code times 8 ms, in ticks
   function automatic logic [9:0] protTicks(input logic [3:0] code);
      protTicks = 10'(code * PROT_STEP_MS * TPMS);
   endfunction

   // ==========================================
   // registers and bus
   tdc_psd_cfg_t psdCfg_ff, nxt_psdCfg;
   tdc_cc_cfg_t  ccCfg_ff, nxt_ccCfg;
   logic [7:0]   rdData_ff, nxt_rdData;
   logic [7:0]   statusWord;

   always_comb begin
      nxt_psdCfg = psdCfg_ff;
      nxt_ccCfg  = ccCfg_ff;
      nxt_rdData = 8'h00;
      // protected: writes without unlock are dropped silently
      if (regReq.wrStb && cfgUnlock) begin
         if (regReq.addr == ADDR_PSD) begin
            nxt_psdCfg = tdc_psd_cfg_t'(regReq.wrData);
         end
         if (regReq.addr == ADDR_CC) begin
            nxt_ccCfg = tdc_cc_cfg_t'(regReq.wrData);
         end
      end
      if (regReq.rdStb) begin
         case (regReq.addr)
            ADDR_PSD:  nxt_rdData = psdCfg_ff;
            ADDR_CC:   nxt_rdData = ccCfg_ff;
            ADDR_STAT: nxt_rdData = statusWord;
            default:   nxt_rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         psdCfg_ff <= tdc_psd_cfg_t'(RST_PSD);
         ccCfg_ff  <= tdc_cc_cfg_t'(RST_CC);
         rdData_ff <= 8'h00;
      end else begin
         psdCfg_ff <= nxt_psdCfg;
         ccCfg_ff  <= nxt_ccCfg;
         rdData_ff <= nxt_rdData;
      end
   end

   // ==========================================
   // 0.125 ms tick divider
   logic [TW-1:0] divCnt_ff, nxt_divCnt;
   logic          tick_ff, nxt_tick;

   always_comb begin
      nxt_tick   = 1'b0;
      nxt_divCnt = divCnt_ff + TW'(1);
      if (divCnt_ff == TW'(TICK_CYCLES - 1)) begin
         nxt_divCnt = '0;
         nxt_tick   = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         divCnt_ff <= '0;
         tick_ff   <= 1'b0;
      end else begin
         divCnt_ff <= nxt_divCnt;
         tick_ff   <= nxt_tick;
      end
   end

   // ==========================================
   // 2100 Hz phase shift evaluation
   tdc_ps_state_t psState_ff, nxt_psState;
   logic [12:0]   evalCnt_ff, nxt_evalCnt;
   logic [12:0]   gapCnt_ff, nxt_gapCnt;
   logic          shift_ff, nxt_shift;
   logic          expired_ff, nxt_expired;
   logic          gapValid;

   // window check; a full gap counter saturates past every limit
   always_comb begin
      gapValid = (gapCnt_ff >= (13'(psdCfg_ff.minInterruptionSelect) + 13'h1) * 13'(MIN_STEP_US / TICK_US))
               && (gapCnt_ff <= maxTicks(psdCfg_ff.maxInterruptionSelect))
               && (psdCfg_ff.longShiftEvalEnable || gapCnt_ff <= LONG_TICKS);
   end

   always_comb begin
      nxt_psState = psState_ff;
      nxt_evalCnt = evalCnt_ff;
      nxt_gapCnt  = gapCnt_ff;
      nxt_shift   = shift_ff;
      nxt_expired = 1'b0;
      case (psState_ff)
         PS_IDLE: begin
            nxt_evalCnt = '0;
            nxt_gapCnt  = '0;
            nxt_shift   = 1'b0;
            if (disTonePresent) begin
               nxt_psState = PS_EVAL;
            end
         end
         PS_EVAL, PS_GAP: begin
            if (tick_ff) begin
               nxt_evalCnt = evalCnt_ff + 13'h1;
               if (psState_ff == PS_GAP && gapCnt_ff != 13'h1FFF) begin
                  nxt_gapCnt = gapCnt_ff + 13'h1;
               end
            end
            if (evalCnt_ff >= evalTicks(psdCfg_ff.evaluationTimeSelect)) begin
               nxt_expired = 1'b1;
               nxt_psState = PS_HOLD;
            end else if (psState_ff == PS_EVAL && !disTonePresent) begin
               nxt_gapCnt  = '0;
               nxt_psState = PS_GAP;
            end else if (psState_ff == PS_GAP && disTonePresent) begin
               if (gapValid) begin
                  nxt_shift   = 1'b1;
                  nxt_psState = PS_HOLD;
               end else begin
                  nxt_psState = PS_EVAL;
               end
            end else if (psState_ff == PS_GAP && gapCnt_ff > maxTicks(3'h7)
                         && gapCnt_ff > LONG_TICKS) begin
               // tone is gone, not interrupted
               nxt_psState = PS_IDLE;
            end
         end
         PS_HOLD: begin
            if (!disTonePresent) begin
               nxt_psState = PS_IDLE;
            end
         end
         default: nxt_psState = PS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         psState_ff <= PS_IDLE;
         evalCnt_ff <= '0;
         gapCnt_ff  <= '0;
         shift_ff   <= 1'b0;
         expired_ff <= 1'b0;
      end else begin
         psState_ff <= nxt_psState;
         evalCnt_ff <= nxt_evalCnt;
         gapCnt_ff  <= nxt_gapCnt;
         shift_ff   <= nxt_shift;
         expired_ff <= nxt_expired;
      end
   end

   // ==========================================
   // 2010 Hz continuity check timing
   logic [9:0] ccCnt_ff, nxt_ccCnt;
   logic       rstDone_ff, nxt_rstDone;
   logic       rstPulse_ff, nxt_rstPulse;
   logic       bypass_ff, nxt_bypass;
   logic       ccEnable;

   always_comb begin
      ccEnable     = (ccCfg_ff != tdc_cc_cfg_t'(RST_CC));
      nxt_ccCnt    = ccCnt_ff;
      nxt_rstDone  = rstDone_ff;
      nxt_rstPulse = 1'b0;
      nxt_bypass   = bypass_ff;
      if (!ccEnable || !ccTonePresent) begin
         nxt_ccCnt   = '0;
         nxt_rstDone = 1'b0;
         nxt_bypass  = 1'b0;
      end else begin
         if (tick_ff && ccCnt_ff != CC_SAT) begin
            nxt_ccCnt = ccCnt_ff + 10'h1;
         end
         // one reset per tone burst, not one per tick
         if (ccCfg_ff.coeffResetProtectTime != 4'h0 && !rstDone_ff
             && ccCnt_ff >= protTicks(ccCfg_ff.coeffResetProtectTime)) begin
            nxt_rstPulse = 1'b1;
            nxt_rstDone  = 1'b1;
         end
         if (ccCfg_ff.bypassProtectTime != 4'h0
             && ccCnt_ff >= protTicks(ccCfg_ff.bypassProtectTime)) begin
            nxt_bypass = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ccCnt_ff    <= '0;
         rstDone_ff  <= 1'b0;
         rstPulse_ff <= 1'b0;
         bypass_ff   <= 1'b0;
      end else begin
         ccCnt_ff    <= nxt_ccCnt;
         rstDone_ff  <= nxt_rstDone;
         rstPulse_ff <= nxt_rstPulse;
         bypass_ff   <= nxt_bypass;
      end
   end

   // ==========================================
   // status and outputs
   always_comb begin
      statusWord = {3'h0, rstDone_ff, bypass_ff, shift_ff,
                    psState_ff == PS_HOLD, psState_ff == PS_EVAL || psState_ff == PS_GAP};
   end

   assign regRdData          = rdData_ff;
   assign phaseShiftDetected = shift_ff;
   assign evalExpired        = expired_ff;
   assign coeffStoreReset    = rstPulse_ff;
   assign cancellerBypass    = bypass_ff;
endmodule // tdc_tone_detector_control

// ===== tb/tdc_monitor.sv
`timescale 1ns/1ns
module tdc_monitor (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  srst,
   // register port
   input wire tdc_pkg::tdc_bus_req_t regReq,
   input wire logic                  cfgUnlock,
   input wire logic [7:0]            regRdData,
   // tones and decisions
   input wire logic                  disTonePresent,
   input wire logic                  ccTonePresent,
   input wire logic                  phaseShiftDetected,
   input wire logic                  evalExpired,
   input wire logic                  coeffStoreReset,
   input wire logic                  cancellerBypass
);
   import tdc_pkg::*;
   logic [7:0] ccCfg_ff;
   logic [7:0] nxt_ccCfg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ==========================================
   // shadow of the continuity byte
   always_comb begin
      nxt_ccCfg = ccCfg_ff;
      if (regReq.wrStb && cfgUnlock && regReq.addr == ADDR_CC)
         nxt_ccCfg = regReq.wrData;
   end
   always_ff @(posedge ref_clk) begin
      if (srst)
         ccCfg_ff <= RST_CC;
      else
         ccCfg_ff <= nxt_ccCfg;
   end
   // ==========================================
   // properties
   sequence s_drop;
      phaseShiftDetected && !disTonePresent;
   endsequence
   property p_rd_idle;
      !regReq.rdStb |=> regRdData == 8'h00;
   endproperty
   property p_unmapped;
      regReq.rdStb && (regReq.addr < ADDR_PSD || regReq.addr > ADDR_STAT) |=> regRdData == 8'h00;
   endproperty
   property p_cc_off;
      ccCfg_ff == 8'h00 |=> !cancellerBypass && !coeffStoreReset;
   endproperty
   property p_bypass_tone;
      cancellerBypass |-> $past(ccTonePresent);
   endproperty
   property p_reset_pulse;
      coeffStoreReset |=> !coeffStoreReset;
   endproperty
   property p_exp_pulse;
      evalExpired |=> !evalExpired;
   endproperty
   property p_shift_rise;
      $rose(phaseShiftDetected) |-> $past(disTonePresent);
   endproperty
   property p_shift_fall;
      s_drop |-> ##[1:2] !phaseShiftDetected;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_cc_off: assert property (p_cc_off) else $error("continuity decision while off");
   a_bypass_tone: assert property (p_bypass_tone) else $error("bypass without tone");
   a_reset_pulse: assert property (p_reset_pulse) else $error("store reset too long");
   a_exp_pulse: assert property (p_exp_pulse) else $error("expiry too long");
   a_shift_rise: assert property (p_shift_rise) else $error("shift without tone");
   a_shift_fall: assert property (p_shift_fall) else $error("shift stays after drop");
endmodule // tdc_monitor

bind tdc_tone_detector_control tdc_monitor mon_u (
   .ref_clk(ref_clk), .srst(srst), .regReq(regReq), .cfgUnlock(cfgUnlock), .regRdData(regRdData),
   .disTonePresent(disTonePresent), .ccTonePresent(ccTonePresent),
   .phaseShiftDetected(phaseShiftDetected), .evalExpired(evalExpired),
   .coeffStoreReset(coeffStoreReset), .cancellerBypass(cancellerBypass)
);

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
   import tdc_pkg::*;
   localparam int T = 4;
   localparam int P = PROT_STEP_MS * US_PER_MS / TICK_US;
   localparam int E = EVAL_MS_0 * US_PER_MS / TICK_US;
   localparam int F = EVAL_MS_1 * US_PER_MS / TICK_US;
   logic         ref_clk;
   logic         srst;
   tdc_bus_req_t regReq;
   logic         cfgUnlock;
   logic [7:0]   regRdData;
   logic         disTonePresent;
   logic         ccTonePresent;
   logic         phaseShiftDetected;
   logic         evalExpired;
   logic         coeffStoreReset;
   logic         cancellerBypass;
   int           errors;
   int           checks_done;
   int           n;
   int           m;
   // short tick keeps the long counts affordable
   tdc_tone_detector_control #(.TICK_CYCLES(T)) dut_u (
      .ref_clk(ref_clk), .srst(srst), .regReq(regReq), .cfgUnlock(cfgUnlock), .regRdData(regRdData),
      .disTonePresent(disTonePresent), .ccTonePresent(ccTonePresent),
      .phaseShiftDetected(phaseShiftDetected), .evalExpired(evalExpired),
      .coeffStoreReset(coeffStoreReset), .cancellerBypass(cancellerBypass));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ==========================================
   // tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic complete_run();
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      @(posedge ref_clk);
      regReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
      cfgUnlock <= u;
      @(posedge ref_clk);
      regReq.wrStb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      regReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
      @(posedge ref_clk);
      regReq.rdStb <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask
   task automatic wait_sig(input int sel, input int lim, output int cnt);
      logic [3:0] v;
      cnt = 0;
      v = 4'h0;
      while (v[sel] !== 1'b1) begin
         @(posedge ref_clk);
         #1;
         v = {evalExpired, phaseShiftDetected, coeffStoreReset, cancellerBypass};
         cnt++;
         if (cnt > lim) begin
            chk(8'h00, 8'h01);
            complete_run();
         end
      end
   endtask
   task automatic start_eval(input logic [7:0] cfg);
      @(posedge ref_clk) disTonePresent <= 1'b0;
      wr(ADDR_PSD, cfg, 1'b1);
      @(posedge ref_clk) disTonePresent <= 1'b1;
      repeat (40) @(posedge ref_clk);
   endtask
   task automatic burst(input logic [7:0] cfg, input int len, input logic exp);
      start_eval(cfg);
      @(posedge ref_clk) disTonePresent <= 1'b0;
      repeat (len) @(posedge ref_clk);
      disTonePresent <= 1'b1;
      repeat (2 * T + 3) @(posedge ref_clk);
      #1;
      chkb(phaseShiftDetected, exp);
   endtask
   // ==========================================
   // sequence
   initial begin
      errors = 0;
      checks_done = 0;
      srst = 1'b1;
      regReq = '0;
      cfgUnlock = 1'b0;
      disTonePresent = 1'b0;
      ccTonePresent = 1'b0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      rd(ADDR_PSD, RST_PSD);
      rd(ADDR_CC, RST_CC);
      rd(8'h20, 8'h00);
      wr(ADDR_PSD, 8'h00, 1'b0);
      rd(ADDR_PSD, RST_PSD);
      wr(ADDR_CC, 8'h21, 1'b1);
      @(posedge ref_clk) ccTonePresent <= 1'b1;
      wait_sig(0, 70 * T, n);
      chkb(n >= P * T - T && n <= P * T + 2 * T, 1'b1);
      wait_sig(1, P * T + 3 * T, m);
      chkb(n + m >= 2 * P * T - T && n + m <= 2 * P * T + 2 * T, 1'b1);
      @(posedge ref_clk) ccTonePresent <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      chkb(cancellerBypass, 1'b0);
      // zero byte: both codes zero, detection off
      wr(ADDR_CC, 8'h00, 1'b1);
      @(posedge ref_clk) ccTonePresent <= 1'b1;
      m = 0;
      repeat (4 * P * T) begin
         @(posedge ref_clk);
         #1;
         if (cancellerBypass !== 1'b0 || coeffStoreReset !== 1'b0)
            m++;
      end
      chkb(m == 0, 1'b1);
      burst(8'h00, 20 * T, 1'b1);
      burst(8'h00, 5 * T, 1'b0);
      burst(8'h00, 230 * T, 1'b0);
      burst(8'h18, 20 * T, 1'b0);
      burst(8'h08, 10 * T, 1'b0);
      burst(8'h08, 20 * T, 1'b1);
      burst(8'h07, 260 * T, 1'b0);
      burst(8'h87, 260 * T, 1'b1);
      start_eval(8'h00);
      wait_sig(3, E * T + 3 * T, n);
      // count starts 40 cycles after the tone edge
      chkb(n + 40 >= E * T - T && n + 40 <= E * T + 2 * T, 1'b1);
      rd(ADDR_STAT, 8'h02);
      start_eval(8'h20);
      wait_sig(3, F * T + 3 * T, n);
      chkb(n + 40 >= F * T - T && n + 40 <= F * T + 2 * T, 1'b1);
      // reset in mid-run brings the protected register back
      @(posedge ref_clk) srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd(ADDR_PSD, RST_PSD);
      complete_run();
   end
endmodule // tb
